// ---- rtl/mdau_consts.svh ----
// Offsets, field positions and reset values of the data addressing unit
`ifndef MDAU_CONSTS_SVH
`define MDAU_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets in the upper direct space
// ----------------------------------------------------------------
`define MDAU_SFR_PTR0_LO    8'h82
`define MDAU_SFR_PTR0_HI    8'h83
`define MDAU_SFR_PTR1_LO    8'h84
`define MDAU_SFR_PTR1_HI    8'h85
`define MDAU_SFR_PTR_SEL    8'h92
`define MDAU_SFR_PAGE_HI    8'hbf
`define MDAU_SFR_PSW        8'hd0

// ----------------------------------------------------------------
// Field positions and areas
// ----------------------------------------------------------------
`define MDAU_PSW_BANK_LO    3
`define MDAU_PSW_BANK_HI    4
`define MDAU_UPPER_BIT      7
`define MDAU_BIT_AREA_BASE  8'h20

// ----------------------------------------------------------------
// Reset values and fill values
// ----------------------------------------------------------------
`define MDAU_RST_BYTE       8'h00
`define MDAU_RST_PTR        16'h0000
`define MDAU_UNIMPL_RDATA   8'h00

`endif

// ---- rtl/mdau_core.sv ----
// Data addressing unit: external move addresses and internal data space
//
// Overview of operation
// - Register-indirect move: low byte from bank R0/R1, high from page.
// - Page register picks one of 256 pages of 256 bytes each.
// - Pointer move drives full 16-bit address from selected pointer.
// - Both external move forms work interchangeably in one program.
// - Select bit 0 chooses primary pointer, bit value 1 the secondary.
// - Changing the select bit leaves both pointer values untouched.
// - Pointer load, increment and move act only on selected pointer.
// - Page register gives upper byte for indirect moves, read or write.
// - Internal data space is 256 bytes with one-byte addresses.
// - Upper 128: direct reaches registers, indirect reaches separate RAM.
// - Lowest 32 bytes are four eight-register banks picked by status bits.
// - Bytes 0x20 to 0x2F are bit addressable.
// - Lower 128 bytes give same storage by direct or indirect access.
// - Unimplemented register reads are free, writes change nothing.
// - Registers with low three address bits zero are bit addressable.
// - Bank bits 00 to 11 map to banks at 0x00, 0x08, 0x10, 0x18.
`timescale 1ns/1ps
`include "mdau_consts.svh"
module mdau_core (
   input  wire logic                mclk,
   input  wire logic                srst,
   input  wire logic                ce,
   input  wire mdau_pkg::mdau_req_t req,
   output mdau_pkg::mdau_rsp_t      rsp
);

   // ----------------------------------------------------------------
   // Decode functions
   // ----------------------------------------------------------------
   function automatic logic [7:0] f_bit_byte(input logic [7:0] baddr);
      if (baddr[`MDAU_UPPER_BIT]) begin
         f_bit_byte = {baddr[7:3], 3'b000};
      end else begin
         f_bit_byte = `MDAU_BIT_AREA_BASE + {4'h0, baddr[6:3]};
      end
   endfunction

   function automatic logic [7:0] f_ri_index(input logic [1:0] bank,
                                             input logic       ri);
      f_ri_index = {3'b000, bank, 2'b00, ri};
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [1:0][15:0]     ptr_ff;
   logic [1:0][15:0]     nxt_ptr;
   logic                 sel_ff;
   logic                 nxt_sel;
   logic [7:0]           page_ff;
   logic [7:0]           nxt_page;
   logic [7:0]           psw_ff;
   logic [7:0]           nxt_psw;
   mdau_pkg::mdau_rsp_t  rsp_ff;
   mdau_pkg::mdau_rsp_t  nxt_rsp;

   assign rsp = rsp_ff;

   // ----------------------------------------------------------------
   // Operation decode
   // ----------------------------------------------------------------
   wire op_rd_dir = req.valid && req.op == mdau_pkg::MDAU_OP_RD_DIR;
   wire op_rd_ind = req.valid && req.op == mdau_pkg::MDAU_OP_RD_IND;
   wire op_wr_dir = req.valid && req.op == mdau_pkg::MDAU_OP_WR_DIR;
   wire op_wr_ind = req.valid && req.op == mdau_pkg::MDAU_OP_WR_IND;
   wire op_bset   = req.valid && req.op == mdau_pkg::MDAU_OP_BIT_SET;
   wire op_bclr   = req.valid && req.op == mdau_pkg::MDAU_OP_BIT_CLR;
   wire op_btst   = req.valid && req.op == mdau_pkg::MDAU_OP_BIT_TST;
   wire op_xri    = req.valid && req.op == mdau_pkg::MDAU_OP_XMV_RI;
   wire op_xptr   = req.valid && req.op == mdau_pkg::MDAU_OP_XMV_PTR;
   wire op_pload  = req.valid && req.op == mdau_pkg::MDAU_OP_PTR_LD;
   wire op_pinc   = req.valid && req.op == mdau_pkg::MDAU_OP_PTR_INC;

   wire op_bit    = op_bset || op_bclr || op_btst;
   wire op_bmod   = op_bset || op_bclr;
   wire upper     = req.addr[`MDAU_UPPER_BIT];

   // ----------------------------------------------------------------
   // Internal data space addressing
   // ----------------------------------------------------------------
   wire [7:0] bit_byte = f_bit_byte(req.addr);
   wire [7:0] byte_idx = op_bit ? bit_byte : req.addr;
   wire [1:0] bank     = psw_ff[`MDAU_PSW_BANK_HI:`MDAU_PSW_BANK_LO];
   wire [7:0] ri_idx   = f_ri_index(bank, req.ri_sel);

   // Register space only for direct and bit access above 0x7f
   wire sfr_path = upper && (op_bit || op_rd_dir || op_wr_dir);
   wire sfr_we   = upper && (op_wr_dir || op_bmod);
   wire ram_we   = op_wr_ind || (!upper && (op_wr_dir || op_bmod));

   logic [7:0] ram_rd;
   logic [7:0] ri_data;
   logic [7:0] sfr_rd;

   wire [7:0] cur_byte = sfr_path ? sfr_rd : ram_rd;
   wire [7:0] bit_mask = 8'h01 << req.addr[2:0];
   wire [7:0] bit_new  = op_bset ? (cur_byte | bit_mask)
                                 : (cur_byte & ~bit_mask);
   wire [7:0] wr_data  = op_bmod ? bit_new : req.wdata;

   mdau_ram u_ram (
      .mclk    (mclk),
      .srst    (srst),
      .ce      (ce),
      .wr_en   (ram_we),
      .wr_idx  (byte_idx),
      .wr_data (wr_data),
      .rd_idx  (byte_idx),
      .rd_data (ram_rd),
      .ri_idx  (ri_idx),
      .ri_data (ri_data)
   );

   // ----------------------------------------------------------------
   // Register read decode
   // ----------------------------------------------------------------
   wire hit_p0l  = byte_idx == `MDAU_SFR_PTR0_LO;
   wire hit_p0h  = byte_idx == `MDAU_SFR_PTR0_HI;
   wire hit_p1l  = byte_idx == `MDAU_SFR_PTR1_LO;
   wire hit_p1h  = byte_idx == `MDAU_SFR_PTR1_HI;
   wire hit_sel  = byte_idx == `MDAU_SFR_PTR_SEL;
   wire hit_page = byte_idx == `MDAU_SFR_PAGE_HI;
   wire hit_psw  = byte_idx == `MDAU_SFR_PSW;

   always_comb begin
      if (hit_p0l) begin
         sfr_rd = ptr_ff[0][7:0];
      end else if (hit_p0h) begin
         sfr_rd = ptr_ff[0][15:8];
      end else if (hit_p1l) begin
         sfr_rd = ptr_ff[1][7:0];
      end else if (hit_p1h) begin
         sfr_rd = ptr_ff[1][15:8];
      end else if (hit_sel) begin
         sfr_rd = {7'h00, sel_ff};
      end else if (hit_page) begin
         sfr_rd = page_ff;
      end else if (hit_psw) begin
         sfr_rd = psw_ff;
      end else begin
         sfr_rd = `MDAU_UNIMPL_RDATA;
      end
   end

   // ----------------------------------------------------------------
   // Data pointers
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_ptr
         wire act   = sel_ff == 1'(gi);
         wire lo_wr = sfr_we && (gi == 0 ? hit_p0l : hit_p1l);
         wire hi_wr = sfr_we && (gi == 0 ? hit_p0h : hit_p1h);
         wire [15:0] inc = ptr_ff[gi] + 16'h0001;
         // Load and increment reach only the selected pointer
         assign nxt_ptr[gi] =
            (op_pload && act) ? req.wide :
            (op_pinc && act)  ? inc :
            {hi_wr ? wr_data : ptr_ff[gi][15:8],
             lo_wr ? wr_data : ptr_ff[gi][7:0]};
      end
   endgenerate

   // ----------------------------------------------------------------
   // Remaining registers; unimplemented writes fall through
   // ----------------------------------------------------------------
   assign nxt_sel  = (sfr_we && hit_sel) ? wr_data[0] : sel_ff;
   assign nxt_page = (sfr_we && hit_page) ? wr_data : page_ff;
   assign nxt_psw  = (sfr_we && hit_psw) ? wr_data : psw_ff;

   // ----------------------------------------------------------------
   // Response
   // ----------------------------------------------------------------
   wire [15:0] ri_xaddr  = {page_ff, ri_data};
   wire [15:0] ptr_xaddr = ptr_ff[sel_ff];

   always_comb begin
      nxt_rsp         = '0;
      nxt_rsp.done    = req.valid;
      if (op_rd_dir || op_rd_ind || op_btst) begin
         nxt_rsp.rdata = cur_byte;
      end
      nxt_rsp.bit_val = op_btst && cur_byte[req.addr[2:0]];
      nxt_rsp.xvalid  = op_xri || op_xptr;
      nxt_rsp.xwrite  = (op_xri || op_xptr) && req.xwr;
      if (op_xri) begin
         nxt_rsp.xaddr = ri_xaddr;
      end else if (op_xptr) begin
         nxt_rsp.xaddr = ptr_xaddr;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         ptr_ff  <= {`MDAU_RST_PTR, `MDAU_RST_PTR};
         sel_ff  <= 1'b0;
         page_ff <= `MDAU_RST_BYTE;
         psw_ff  <= `MDAU_RST_BYTE;
         rsp_ff  <= '0;
      end else if (ce) begin
         ptr_ff  <= nxt_ptr;
         sel_ff  <= nxt_sel;
         page_ff <= nxt_page;
         psw_ff  <= nxt_psw;
         rsp_ff  <= nxt_rsp;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   sequence s_xri;
      ce && op_xri;
   endsequence

   sequence s_xptr;
      ce && op_xptr;
   endsequence

   sequence s_sel_write;
      ce && sfr_we && hit_sel;
   endsequence

   sequence s_inc;
      ce && op_pinc;
   endsequence

   sequence s_load;
      ce && op_pload;
   endsequence

   ri_paged_a: assert property (
      s_xri |=> rsp_ff.xvalid && rsp_ff.xaddr ==
         {$past(page_ff), $past(ri_data)})
      else $error("paged external address wrong");

   page_high_a: assert property (
      s_xri |=> rsp_ff.xaddr[15:8] == $past(page_ff)
         && rsp_ff.xwrite == $past(req.xwr))
      else $error("page byte or direction lost");

   ptr_move_a: assert property (
      s_xptr |=> rsp_ff.xvalid && rsp_ff.xaddr == $past(ptr_xaddr))
      else $error("pointer external address wrong");

   sel_primary_a: assert property (
      s_xptr and (sel_ff == 1'b0) |=> rsp_ff.xaddr == $past(ptr_ff[0]))
      else $error("select zero did not pick primary pointer");

   sel_keep_a: assert property (
      s_sel_write ##0 (!op_pload && !op_pinc) |=>
         ptr_ff == $past(ptr_ff))
      else $error("pointer changed by select write");

   inc_selected_a: assert property (
      s_inc |=> ptr_ff[$past(sel_ff)] == $past(ptr_ff[sel_ff]) + 16'h0001
         && ptr_ff[!$past(sel_ff)] == $past(ptr_ff[!sel_ff]))
      else $error("increment hit wrong pointer");

   bank_map_a: assert property (
      ce && op_xri && psw_ff[4:3] == 2'b11 && req.ri_sel |->
         ri_idx == 8'h19)
      else $error("bank three R1 index wrong");

   unimpl_read_a: assert property (
      ce && op_rd_dir && upper && !(hit_p0l || hit_p0h || hit_p1l ||
         hit_p1h || hit_sel || hit_page || hit_psw) |=>
         rsp_ff.rdata == 8'h00)
      else $error("unimplemented register read not zero");

   unimpl_write_a: assert property (
      ce && op_wr_dir && upper && !(hit_p0l || hit_p0h || hit_p1l ||
         hit_p1h || hit_sel || hit_page || hit_psw) |=>
         $stable(ptr_ff) && $stable(sel_ff) && $stable(page_ff)
         && $stable(psw_ff))
      else $error("unimplemented register write changed state");

   lower_both_a: assert property (
      ce && op_rd_ind && !upper && $past(ce && op_wr_dir) &&
         $past(req.addr) == req.addr |=>
         rsp_ff.rdata == $past(req.wdata, 2))
      else $error("direct write not seen by indirect read");

   bit_area_a: assert property (
      ce && op_btst && !upper && $past(ce && op_bset) &&
         $past(req.addr) == req.addr |=> rsp_ff.bit_val)
      else $error("bit set not seen by bit test");

   // ----------------------------------------------------------------
   // Pointer, external move and address space checks
   // ----------------------------------------------------------------

   load_selected_a: assert property (
      s_load |=> ptr_ff[$past(sel_ff)] == $past(req.wide)
         && ptr_ff[!$past(sel_ff)] == $past(ptr_ff[!sel_ff]))
      else $error("pointer load hit wrong pointer");

   page_top_a: assert property (
      s_xri ##0 (page_ff == 8'hff) |=> rsp_ff.xaddr[15:8] == 8'hff)
      else $error("top page not reachable");

   move_valid_a: assert property (
      ce && (op_xri || op_xptr) |=> rsp_ff.xvalid && rsp_ff.done)
      else $error("external move not flagged");

   move_idle_a: assert property (
      ce && !(op_xri || op_xptr) |=> !rsp_ff.xvalid
         && rsp_ff.xaddr == 16'h0000 && !rsp_ff.xwrite)
      else $error("external address shown without a move");

   ind_upper_a: assert property (
      ce && op_wr_ind && upper |=> $stable(ptr_ff) && $stable(sel_ff)
         && $stable(page_ff) && $stable(psw_ff))
      else $error("indirect upper write reached registers");

   dir_upper_a: assert property (
      ce && op_rd_dir && hit_psw |=> rsp_ff.rdata == $past(psw_ff))
      else $error("direct read missed status word");

   bank_index_a: assert property (
      ce && op_xri |-> ri_idx[7:5] == 3'b000 && ri_idx[2:1] == 2'b00
         && ri_idx[4:3] == psw_ff[`MDAU_PSW_BANK_HI:`MDAU_PSW_BANK_LO]
         && ri_idx[0] == req.ri_sel)
      else $error("working register index outside active bank");

   psw_bit_a: assert property (
      ce && op_bset && req.addr[7:3] == 5'h1a |=>
         psw_ff[$past(req.addr[2:0])])
      else $error("bit set on status word lost");

   unimpl_ram_a: assert property (
      ce && op_wr_dir && upper |-> !ram_we)
      else $error("register write leaked into RAM");

   bit_clear_a: assert property (
      ce && op_bclr && !upper |-> !wr_data[req.addr[2:0]]
         && bit_byte[7:4] == 4'h2)
      else $error("bit clear outside bit area");

endmodule

// ---- rtl/mdau_pkg.sv ----
// Types of the data addressing unit
package mdau_pkg;

   // ----------------------------------------------------------------
   // Request operations
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      MDAU_OP_NOP     = 4'h0,
      MDAU_OP_RD_DIR  = 4'h1,
      MDAU_OP_RD_IND  = 4'h2,
      MDAU_OP_WR_DIR  = 4'h3,
      MDAU_OP_WR_IND  = 4'h4,
      MDAU_OP_BIT_SET = 4'h5,
      MDAU_OP_BIT_CLR = 4'h6,
      MDAU_OP_BIT_TST = 4'h7,
      MDAU_OP_XMV_RI  = 4'h8,
      MDAU_OP_XMV_PTR = 4'h9,
      MDAU_OP_PTR_LD  = 4'ha,
      MDAU_OP_PTR_INC = 4'hb
   } mdau_op_t;

   // ----------------------------------------------------------------
   // Request and response carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        valid;
      mdau_op_t    op;
      logic [7:0]  addr;
      logic [7:0]  wdata;
      logic [15:0] wide;
      logic        ri_sel;
      logic        xwr;
   } mdau_req_t;

   typedef struct packed {
      logic        done;
      logic [7:0]  rdata;
      logic        bit_val;
      logic        xvalid;
      logic        xwrite;
      logic [15:0] xaddr;
   } mdau_rsp_t;

endpackage

// ---- rtl/mdau_ram.sv ----
// Internal data RAM, 256 bytes, one write and two read ports
`timescale 1ns/1ps
`include "mdau_consts.svh"
module mdau_ram (
   input  wire logic        mclk,
   input  wire logic        srst,
   input  wire logic        ce,
   input  wire logic        wr_en,
   input  wire logic [7:0]  wr_idx,
   input  wire logic [7:0]  wr_data,
   input  wire logic [7:0]  rd_idx,
   output logic      [7:0]  rd_data,
   input  wire logic [7:0]  ri_idx,
   output logic      [7:0]  ri_data
);

   logic [7:0] mem_ff [0:255];

   assign rd_data = mem_ff[rd_idx];
   assign ri_data = mem_ff[ri_idx];

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 256; gi++) begin : g_byte
         always_ff @(posedge mclk) begin
            if (srst) begin
               mem_ff[gi] <= `MDAU_RST_BYTE;
            end else if (ce && wr_en && wr_idx == 8'(gi)) begin
               mem_ff[gi] <= wr_data;
            end
         end
      end
   endgenerate

endmodule

// ---- verif/mdau_xmem.sv ----
// External data memory model that records external move addresses
`timescale 1ns/1ps
module mdau_xmem (
   input  wire logic                mclk,
   input  wire logic                srst,
   input  wire logic                ce,
   input  wire mdau_pkg::mdau_rsp_t rsp,
   output logic [15:0]              last_addr,
   output logic                     last_wr
);
   // Latch each external address one edge after the core presents it
   always_ff @(posedge mclk) begin
      if (srst) begin
         last_addr <= 16'h0000;
         last_wr   <= 1'b0;
      end else if (ce && rsp.xvalid) begin
         last_addr <= rsp.xaddr;
         last_wr   <= rsp.xwrite;
      end
   end
endmodule

// ---- verif/tb.sv ----
// Testbench of the data addressing unit
`timescale 1ns/1ps
`include "mdau_consts.svh"
module tb;
   logic                mclk     = 1'b0;
   logic                srst     = 1'b1;
   logic                ce       = 1'b1;
   mdau_pkg::mdau_req_t req      = '0;
   mdau_pkg::mdau_rsp_t rsp;
   logic [15:0]         seen_addr;
   logic                seen_wr;
   int                  errors   = 0;
   int                  n_checks = 0;

   always #5 mclk = ~mclk;

   mdau_core uut (.mclk(mclk), .srst(srst), .ce(ce), .req(req), .rsp(rsp));
   mdau_xmem xm (.mclk(mclk), .srst(srst), .ce(ce), .rsp(rsp),
                 .last_addr(seen_addr), .last_wr(seen_wr));

   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   // One request, answer read just after the edge that takes it
   task automatic op(input mdau_pkg::mdau_op_t o, input logic [7:0] a,
                     input logic [7:0] d, input logic [15:0] w,
                     input logic r, input logic x);
      @(posedge mclk);
      req <= '{1'b1, o, a, d, w, r, x};
      @(posedge mclk);
      req.valid <= 1'b0;
      #1;
      chk("done", 16'h0001, {15'h0000, rsp.done});
   endtask

   task automatic bo(input mdau_pkg::mdau_op_t o, input logic [7:0] a);
      op(o, a, 8'h00, 16'h0000, 1'b0, 1'b0);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic i);
      op(mdau_pkg::mdau_op_t'(i ? mdau_pkg::MDAU_OP_WR_IND
                                : mdau_pkg::MDAU_OP_WR_DIR),
         a, d, 16'h0000, 1'b0, 1'b0);
   endtask

   task automatic rd(input string n, input logic [7:0] a, input logic i,
                     input logic [7:0] e);
      bo(mdau_pkg::mdau_op_t'(i ? mdau_pkg::MDAU_OP_RD_IND
                                : mdau_pkg::MDAU_OP_RD_DIR), a);
      chk(n, {8'h00, e}, {8'h00, rsp.rdata});
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      logic [7:0] regs [8];
      regs = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h92, 8'hbf, 8'hd0, 8'h81};
      for (int i = 0; i < 8; i++) begin
         rd("rst_reg", regs[i], 1'b0, 8'h00);
      end
      rd("rst_ram", 8'hff, 1'b1, 8'h00);
   endtask

   task automatic t_paged;
      logic [7:0] pg;
      logic [7:0] lo;
      for (int b = 0; b < 4; b++) begin
         pg = 8'hfc | 8'(b);
         lo = b[0] ? (8'h40 | 8'(b)) : (8'h10 | 8'(b));
         wr(`MDAU_SFR_PSW, 8'he7 | 8'(b << 3), 1'b0);
         wr(8'(b * 8), 8'h10 | 8'(b), 1'b1);
         wr(8'(b * 8 + 1), 8'h40 | 8'(b), 1'b1);
         wr(`MDAU_SFR_PAGE_HI, pg, 1'b0);
         op(mdau_pkg::MDAU_OP_XMV_RI, 8'h00, 8'h00, 16'h0000, b[0], b[1]);
         chk("xaddr_ri", {pg, lo}, rsp.xaddr);
         chk("xvalid", 16'h0001, {15'h0000, rsp.xvalid});
         chk("xwrite", {15'h0000, b[1]}, {15'h0000, rsp.xwrite});
         @(posedge mclk);
         #1;
         chk("xmem_addr", {pg, lo}, seen_addr);
         chk("xmem_wr", {15'h0000, b[1]}, {15'h0000, seen_wr});
      end
   endtask

   task automatic t_ptr;
      op(mdau_pkg::MDAU_OP_PTR_LD, 8'h00, 8'h00, 16'h1234, 1'b0, 1'b0);
      wr(`MDAU_SFR_PTR_SEL, 8'hff, 1'b0);
      rd("sel", `MDAU_SFR_PTR_SEL, 1'b0, 8'h01);
      op(mdau_pkg::MDAU_OP_PTR_LD, 8'h00, 8'h00, 16'hffff, 1'b0, 1'b0);
      bo(mdau_pkg::MDAU_OP_PTR_INC, 8'h00);
      bo(mdau_pkg::MDAU_OP_XMV_PTR, 8'h00);
      chk("xaddr_p1", 16'h0000, rsp.xaddr);
      rd("p0_lo", `MDAU_SFR_PTR0_LO, 1'b0, 8'h34);
      rd("p0_hi", `MDAU_SFR_PTR0_HI, 1'b0, 8'h12);
      wr(`MDAU_SFR_PTR1_HI, 8'hab, 1'b0);
      wr(`MDAU_SFR_PTR_SEL, 8'h00, 1'b0);
      bo(mdau_pkg::MDAU_OP_XMV_PTR, 8'h00);
      chk("xaddr_p0", 16'h1234, rsp.xaddr);
      bo(mdau_pkg::MDAU_OP_XMV_RI, 8'h00);
      chk("xaddr_mix", 16'hff13, rsp.xaddr);
      wr(`MDAU_SFR_PTR_SEL, 8'h01, 1'b0);
      bo(mdau_pkg::MDAU_OP_XMV_PTR, 8'h00);
      chk("xaddr_p1b", 16'hab00, rsp.xaddr);
   endtask

   task automatic t_space;
      wr(8'h40, 8'h5a, 1'b0);
      rd("lo_ind", 8'h40, 1'b1, 8'h5a);
      wr(8'h7f, 8'ha5, 1'b1);
      rd("lo_dir", 8'h7f, 1'b0, 8'ha5);
      wr(8'h90, 8'h77, 1'b1);
      rd("up_dir", 8'h90, 1'b0, 8'h00);
      rd("up_ind", 8'h90, 1'b1, 8'h77);
      rd("psw_ind", 8'hd0, 1'b1, 8'h00);
      wr(8'h81, 8'h3c, 1'b0);
      rd("unimpl", 8'h81, 1'b0, 8'h00);
      rd("unimpl_ram", 8'h81, 1'b1, 8'h00);
      wr(8'hff, 8'h99, 1'b1);
      rd("top_ind", 8'hff, 1'b1, 8'h99);
      rd("no_alias", 8'h7f, 1'b1, 8'ha5);
   endtask

   task automatic t_bits;
      bo(mdau_pkg::MDAU_OP_BIT_SET, 8'h05);
      rd("bit_set", 8'h20, 1'b0, 8'h20);
      bo(mdau_pkg::MDAU_OP_BIT_SET, 8'h7f);
      rd("bit_top", 8'h2f, 1'b0, 8'h80);
      bo(mdau_pkg::MDAU_OP_BIT_TST, 8'h05);
      chk("bit_tst", 16'h0001, {15'h0000, rsp.bit_val});
      bo(mdau_pkg::MDAU_OP_BIT_CLR, 8'h05);
      rd("bit_clr", 8'h20, 1'b0, 8'h00);
      wr(`MDAU_SFR_PSW, 8'h00, 1'b0);
      bo(mdau_pkg::MDAU_OP_BIT_SET, 8'hd3);
      bo(mdau_pkg::MDAU_OP_BIT_SET, 8'hd1);
      rd("psw_bits", `MDAU_SFR_PSW, 1'b0, 8'h0a);
   endtask

   task automatic t_ce;
      @(posedge mclk);
      req <= '{1'b1, mdau_pkg::MDAU_OP_RD_DIR, `MDAU_SFR_PSW, 8'h00,
               16'h0000, 1'b0, 1'b0};
      @(posedge mclk);
      req.valid <= 1'b0;
      ce        <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      chk("ce_hold", 16'h010a, {7'h00, rsp.done, rsp.rdata});
      @(posedge mclk);
      ce <= 1'b1;
   endtask

   // Back-to-back requests: each one sees the previous write
   task automatic t_b2b;
      @(posedge mclk);
      req <= '{1'b1, mdau_pkg::MDAU_OP_WR_DIR, 8'h41, 8'hc3, 16'h0000,
               1'b0, 1'b0};
      @(posedge mclk);
      req <= '{1'b1, mdau_pkg::MDAU_OP_RD_IND, 8'h41, 8'h00, 16'h0000,
               1'b0, 1'b0};
      @(posedge mclk);
      req <= '{1'b1, mdau_pkg::MDAU_OP_BIT_SET, 8'h0a, 8'h00, 16'h0000,
               1'b0, 1'b0};
      #1;
      chk("b2b_rd", 16'h00c3, {8'h00, rsp.rdata});
      @(posedge mclk);
      req <= '{1'b1, mdau_pkg::MDAU_OP_BIT_TST, 8'h0a, 8'h00, 16'h0000,
               1'b0, 1'b0};
      @(posedge mclk);
      req.valid <= 1'b0;
      #1;
      chk("b2b_bit", 16'h0001, {15'h0000, rsp.bit_val});
   endtask

   task automatic final_report;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge mclk);
      srst <= 1'b0;
      t_reset();
      t_paged();
      t_ptr();
      t_space();
      t_bits();
      t_b2b();
      t_ce();
      final_report();
   end

   initial begin
      repeat (5000) @(posedge mclk);
      errors++;
      final_report();
   end
endmodule
